// *** hw/amb_cfg.svh ***
`ifndef AMB_CFG_SVH
`define AMB_CFG_SVH
// beep path gain, 0.3 V/V in tenths
`define AMB_BEEP_GAIN_TENTHS 4'h3
// valid beep needs this many rising edges
`define AMB_EDGE_MIN         4'h8
// loss timeout in sampling cycles (100 us at 200 MHz)
`define AMB_TIMEOUT_US       100
`define AMB_CLK_MHZ          200
`define AMB_TIMEOUT_CYC      (`AMB_TIMEOUT_US * `AMB_CLK_MHZ)
// volume code width
`define AMB_VOL_W            5
`endif

// *** hw/amb_pkg.sv ***
package amb_pkg;
  // beep detector states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_COUNT = 3'b010,
    ST_VALID = 3'b100
  } amb_det_t;
endpackage

// *** hw/amb_mode_sel.sv ***
// Functional notes
// - select low: followers on, bridged mode
// - select high: followers hi-z, single-ended
// - beep: inputs deselected, bridged from beep
// - beep gain fixed 0.3, volume ignored
// - beep end takes mode, volume from live pins
// - beep overrides shutdown, returns afterwards
// - force low: auto beep on valid signal
// - valid after at least 8 rising edges
// - auto beep ends when signal lost
// - force high: beep mode, overriding all but overtemperature
// - unconnected force reads low (pulldown); this module has no pull on the force pin
// - overtemperature above 150 C turns off
// - sleep request low mutes outputs
`timescale 1ns/1ps
`default_nettype none
`include "amb_cfg.svh"
module amb_mode_sel #(
  parameter int unsigned TIMEOUT_CYC = `AMB_TIMEOUT_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   output_config_select_i,
  input  wire logic                   beep_force_select_i,
  input  wire logic                   sleep_request_n_i,
  input  wire logic                   beep_input_i,
  input  wire logic                   over_temp_i,
  input  wire logic [`AMB_VOL_W-1:0]  volume_i,
  output logic                        follower_en_o,
  output logic                        primary_en_o,
  output logic                        bridged_o,
  output logic                        line_sel_o,
  output logic                        headphone_sel_o,
  output logic                        beep_sel_o,
  output logic                        mute_o,
  output logic                        low_power_o,
  output logic [3:0]                  beep_gain_o,
  output logic [`AMB_VOL_W-1:0]       volume_o
);
  // two-stage synchronisers; only stage 2 is read
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r <= 5'h0;
      s2_r <= 5'h0;
    end else begin
      s1_r <= {over_temp_i, beep_input_i, sleep_request_n_i,
               beep_force_select_i, output_config_select_i};
      s2_r <= s1_r;
    end
  end

  wire cfg_se   = s2_r[0];
  // force pin has no pull here, so a floating pin is not read low; reset value low
  wire force_hi = s2_r[1];
  wire awake    = s2_r[2];
  wire beep_lvl = s2_r[3];
  wire hot      = s2_r[4];

  // edge detect on the synchronised beep level
  logic beep_d_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) beep_d_r <= 1'b0;
    else beep_d_r <= beep_lvl;
  end
  wire rise = beep_lvl & ~beep_d_r;

  // detector: edge counter plus loss timer
  amb_pkg::amb_det_t st_r, st_nxt;
  logic [3:0]  edges_r, edges_nxt;
  logic [31:0] idle_r, idle_nxt;
  wire timed_out = (idle_r >= TIMEOUT_CYC - 1);

  always_comb begin
    st_nxt    = st_r;
    edges_nxt = edges_r;
    idle_nxt  = rise ? 32'h0 : idle_r + 32'h1;
    unique case (st_r)
      amb_pkg::ST_IDLE: begin
        idle_nxt = 32'h0;
        if (rise) begin
          edges_nxt = 4'h1;
          st_nxt    = amb_pkg::ST_COUNT;
        end
      end
      amb_pkg::ST_COUNT: begin
        if (!rise && timed_out) begin
          edges_nxt = 4'h0;
          st_nxt    = amb_pkg::ST_IDLE;
        end else if (rise) begin
          edges_nxt = edges_r + 4'h1;
          if (edges_r + 4'h1 >= `AMB_EDGE_MIN)
            st_nxt = amb_pkg::ST_VALID;
        end
      end
      amb_pkg::ST_VALID: begin
        if (!rise && timed_out) begin
          edges_nxt = 4'h0;
          st_nxt    = amb_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt    = amb_pkg::ST_IDLE;
        edges_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r    <= amb_pkg::ST_IDLE;
      edges_r <= 4'h0;
      idle_r  <= 32'h0;
    end else begin
      st_r    <= st_nxt;
      edges_r <= edges_nxt;
      idle_r  <= idle_nxt;
    end
  end

  // beep mode: forced, or auto after valid detection
  wire beep_mode = force_hi | (st_r == amb_pkg::ST_VALID);

  // saved volume: frozen while in beep, live otherwise
  logic [`AMB_VOL_W-1:0] vol_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) vol_r <= '0;
    else if (!beep_mode) vol_r <= volume_i;
  end

  // mode is recomputed from live pins; beep only overlays it
  wire active   = ~hot & (beep_mode | awake);
  wire btl      = beep_mode | ~cfg_se;
  wire line_n   = active & ~beep_mode & ~cfg_se;
  wire hp_n     = active & ~beep_mode & cfg_se;

  // registered outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      follower_en_o   <= 1'b0;
      primary_en_o    <= 1'b0;
      bridged_o       <= 1'b0;
      line_sel_o      <= 1'b0;
      headphone_sel_o <= 1'b0;
      beep_sel_o      <= 1'b0;
      mute_o          <= 1'b1;
      low_power_o     <= 1'b1;
      beep_gain_o     <= 4'h0;
      volume_o        <= '0;
    end else begin
      follower_en_o   <= active & btl;
      primary_en_o    <= active;
      bridged_o       <= active & btl;
      line_sel_o      <= line_n;
      headphone_sel_o <= hp_n;
      beep_sel_o      <= active & beep_mode;
      mute_o          <= ~active;
      low_power_o     <= ~active;
      beep_gain_o     <= (active & beep_mode) ?
                         `AMB_BEEP_GAIN_TENTHS : 4'h0;
      volume_o        <= beep_mode ? vol_r : volume_i;
    end
  end

  // assertions
  // auto detection can hold beep while the pin rests low, so use beep_mode
  property p_btl_low;
    @(posedge clk_i) disable iff (!resetn_i)
      (!beep_mode && !cfg_se && awake && !hot)
        |=> (follower_en_o && bridged_o && line_sel_o);
  endproperty
  a_btl_low: assert property (p_btl_low) else $error("btl not selected");
  property p_se_high;
    @(posedge clk_i) disable iff (!resetn_i)
      (!beep_mode && cfg_se) |=> !follower_en_o;
  endproperty
  a_se_high: assert property (p_se_high) else $error("follower on in se");
  property p_beep_out;
    @(posedge clk_i) disable iff (!resetn_i)
      (beep_mode && !hot) |=> (beep_sel_o && bridged_o && !line_sel_o
                               && !headphone_sel_o);
  endproperty
  a_beep_out: assert property (p_beep_out) else $error("beep routing");
  property p_gain;
    @(posedge clk_i) disable iff (!resetn_i)
      beep_sel_o |-> beep_gain_o == 4'h3;
  endproperty
  a_gain: assert property (p_gain) else $error("beep gain wrong");
  property p_vol_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      (beep_mode && $past(beep_mode)) |-> $stable(vol_r);
  endproperty
  a_vol_hold: assert property (p_vol_hold) else $error("volume lost");
  property p_sleep_beep;
    @(posedge clk_i) disable iff (!resetn_i)
      (!awake && !hot && beep_mode) |=> !mute_o;
  endproperty
  a_sleep_beep: assert property (p_sleep_beep) else $error("no wake");
  property p_valid;
    @(posedge clk_i) disable iff (!resetn_i)
      (st_r == amb_pkg::ST_COUNT && st_nxt == amb_pkg::ST_VALID)
        |-> edges_r == 4'h7;
  endproperty
  a_valid: assert property (p_valid) else $error("early valid");
  property p_force;
    @(posedge clk_i) disable iff (!resetn_i)
      (force_hi && !hot) [*2] |=> beep_sel_o;
  endproperty
  a_force: assert property (p_force) else $error("force ignored");
  // without force, beep needs a valid train first
  property p_auto_only;
    @(posedge clk_i) disable iff (!resetn_i)
      (!force_hi && st_r != amb_pkg::ST_VALID) |=> !beep_sel_o;
  endproperty
  a_auto_only: assert property (p_auto_only) else $error("early beep");
  property p_hot;
    @(posedge clk_i) disable iff (!resetn_i)
      hot |=> (mute_o && !primary_en_o);
  endproperty
  a_hot: assert property (p_hot) else $error("no thermal off");
  property p_sleep;
    @(posedge clk_i) disable iff (!resetn_i)
      (!awake && !beep_mode) |=> (mute_o && low_power_o);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep ignored");
  property p_tmo;
    @(posedge clk_i) disable iff (!resetn_i)
      (st_r != amb_pkg::ST_IDLE && timed_out && !rise)
        |=> (st_r == amb_pkg::ST_IDLE && edges_r == 4'h0);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout missed");
  c_auto: cover property (@(posedge clk_i) st_r == amb_pkg::ST_VALID);
  c_lost: cover property (@(posedge clk_i)
    st_r == amb_pkg::ST_VALID ##1 st_r == amb_pkg::ST_IDLE);
  c_wake: cover property (@(posedge clk_i) !awake && beep_sel_o);
endmodule
`default_nettype wire

// *** bench/amb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module amb_host_model (
  input  wire logic clk_i,
  output logic      beep_o
);
  // idle level is low, as the digitised pin rests between beeps
  initial beep_o = 1'b0;
  // square train, two cycles high and two low, so each edge is seen
  task automatic send(input int n);
    repeat (n) begin
      @(posedge clk_i);
      beep_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      beep_o <= 1'b0;
      @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// *** bench/tb_amb_mode_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "amb_cfg.svh"
module tb_amb_mode_sel;
  logic                  clk_i = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  cfg = 1'b0, frc = 1'b0, slp_n = 1'b1, ot = 1'b0;
  logic [`AMB_VOL_W-1:0] vol = 5'h0a, volo;
  logic                  fol, pri, brg, lin, hp, bsel, mute, lp;
  logic [3:0]            gain;
  wire                   beep;
  int                    miscompares = 0, samples_checked = 0;

  // free-running 200 MHz clock
  initial forever #2.5 clk_i = ~clk_i;

  amb_mode_sel #(.TIMEOUT_CYC(50)) amb_mode_sel_inst (
    .clk_i(clk_i), .resetn_i(rst_n), .output_config_select_i(cfg),
    .beep_force_select_i(frc), .sleep_request_n_i(slp_n),
    .beep_input_i(beep), .over_temp_i(ot), .volume_i(vol),
    .follower_en_o(fol), .primary_en_o(pri), .bridged_o(brg),
    .line_sel_o(lin), .headphone_sel_o(hp), .beep_sel_o(bsel),
    .mute_o(mute), .low_power_o(lp), .beep_gain_o(gain),
    .volume_o(volo));
  amb_host_model amb_host_model_inst (.clk_i(clk_i), .beep_o(beep));

  // wide enough for the 14-bit restore compare
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // let the two sync flops and the output register land
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic stop_test();
    $display("checked %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog, far beyond the roughly 1.2 us of tests
  initial begin
    #20us;
    miscompares++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n <= 1'b1;
    settle(4);
    chk({fol, pri, brg, lin, hp, bsel, mute}, 7'b1111000);
    $display("test bridged done");
    @(posedge clk_i) cfg <= 1'b1;
    settle(4);
    chk({fol, pri, brg, lin, hp, bsel}, 6'b010010);
    $display("test single-ended done");
    @(posedge clk_i) frc <= 1'b1;
    settle(4);
    chk({fol, brg, lin, hp, bsel, gain}, {5'b11001, 4'h3});
    @(posedge clk_i) vol <= 5'h11;
    settle(4);
    chk(volo, 5'h0a);
    @(posedge clk_i) frc <= 1'b0;
    settle(4);
    chk({fol, pri, brg, hp, bsel, gain, volo}, {5'b01010, 4'h0, 5'h11});
    $display("test forced beep done");
    @(posedge clk_i) begin
      cfg <= 1'b0;
      slp_n <= 1'b0;
    end
    settle(4);
    chk({mute, lp, lin, hp}, 4'b1100);
    @(posedge clk_i) frc <= 1'b1;
    settle(4);
    chk({mute, bsel, brg}, 3'b011);
    @(posedge clk_i) frc <= 1'b0;
    settle(4);
    chk({mute, bsel}, 2'b10);
    @(posedge clk_i) slp_n <= 1'b1;
    $display("test beep over sleep done");
    amb_host_model_inst.send(7);
    settle(4);
    chk(bsel, 1'b0);
    settle(60);
    amb_host_model_inst.send(8);
    settle(4);
    chk({bsel, brg, lin, gain}, {3'b110, 4'h3});
    settle(60);
    chk({bsel, lin, gain}, {2'b01, 4'h0});
    $display("test auto beep done");
    @(posedge clk_i) ot <= 1'b1;
    settle(4);
    chk(mute, 1'b1);
    $display("test overtemp done");
    stop_test();
  end
endmodule
`default_nettype wire
